// *** design/crr_release.sv ***
// contact release logic with timed reset acknowledgement
//
// Summary of operation
// - the release-condition output is the AND of all enabled release inputs.
// - the input count is configurable 2 to 8, so 1 to 7 release inputs take part.
// - reset-required toggles at 1 Hz while waiting for a valid reset pulse.
// - reset-required is only active while the condition holds and release is low.
// - release rises after a valid reset pulse under the condition and stays high while inputs stay high.
// - the minimum reset pulse is selectable as 100 ms or 350 ms.
// - reset pulses shorter than the minimum or longer than 30 s are ignored.
// - release drops at once when any enabled input goes low and needs a fresh pulse.
`timescale 1ns/10ps
`include "crr_params.svh"
module crr_release #(
   parameter int TICK_CYC = `CRR_TICK_CYC // ms tick length in clock cycles
) (
   input  wire logic                               mclk,
   input  wire logic                               reset_n,
   input  wire logic [`CRR_NUM_REL-1:0]            release_in,
   input  wire logic                               reset_btn,
   input  wire crr_pkg::crr_cfg_type               cfg,
   output crr_pkg::crr_out_type                    status
);
   localparam int TICK_W    = $clog2(TICK_CYC);
   localparam logic [14:0] MAX_MS   = 15'(`CRR_MAX_PULSE_MS);
   localparam logic [14:0] SHORT_MS = 15'(`CRR_MIN_SHORT_MS);
   localparam logic [14:0] LONG_MS  = 15'(`CRR_MIN_LONG_MS);
   localparam logic [9:0]  BLINK_MS = 10'(`CRR_BLINK_HALF_MS);

   logic [`CRR_NUM_REL-1:0] rel_s;
   logic                    btn_s;
   logic [`CRR_NUM_REL-1:0] enable_mask;
   logic                    cond;
   logic [TICK_W-1:0]       tick_cnt_q;
   logic                    tick_q;
   logic [14:0]             press_ms_q;
   logic [9:0]              blink_ms_q;
   logic                    blink_q;
   logic [14:0]             min_ms;
   logic                    pulse_ok;
   crr_pkg::crr_state_type  state_q;

   // pins cross into the clock domain
   crr_sync #(.WIDTH(`CRR_NUM_REL + 1)) u_sync (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .async_in ({reset_btn, release_in}),
      .sync_out ({btn_s, rel_s})
   );

   // per-input enable, unused inputs are forced true
   genvar gi;
   generate
      for (gi = 0; gi < `CRR_NUM_REL; gi++)
      begin : g_en
         assign enable_mask[gi] = (4'(gi + 2) <= cfg.num_inputs);
      end
   endgenerate

   assign cond   = &(rel_s | ~enable_mask);
   assign min_ms = cfg.min_long ? LONG_MS : SHORT_MS;
   // released button: length within the window counts as valid
   assign pulse_ok = (press_ms_q >= min_ms) && (press_ms_q <= MAX_MS);

   // millisecond tick from the system clock
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end
      else if (tick_cnt_q == TICK_W'(TICK_CYC - 1))
      begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b1;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
         tick_q     <= 1'b0;
      end
   end

   // press length in ms, saturating above the upper limit
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         press_ms_q <= '0;
      else if (!btn_s)
         press_ms_q <= '0;
      else if (tick_q && press_ms_q <= MAX_MS)
         press_ms_q <= press_ms_q + 1'b1;
   end

   // 1 Hz blink, restarts whenever waiting begins
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         blink_ms_q <= '0;
         blink_q    <= 1'b0;
      end
      else if (state_q == crr_pkg::CRR_IDLE || state_q == crr_pkg::CRR_RELEASE)
      begin
         blink_ms_q <= '0;
         blink_q    <= 1'b1;
      end
      else if (tick_q)
      begin
         if (blink_ms_q == BLINK_MS - 10'h001)
         begin
            blink_ms_q <= '0;
            blink_q    <= ~blink_q;
         end
         else
            blink_ms_q <= blink_ms_q + 10'h001;
      end
   end

   // release sequencing
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         state_q <= crr_pkg::CRR_IDLE;
      else if (!cond)
         state_q <= crr_pkg::CRR_IDLE;
      else
      begin
         unique case (state_q)
            crr_pkg::CRR_IDLE:
               state_q <= btn_s ? crr_pkg::CRR_IDLE : crr_pkg::CRR_WAIT; // a held button must be let go first
            crr_pkg::CRR_WAIT:
               if (btn_s)
                  state_q <= crr_pkg::CRR_PRESSED;
            crr_pkg::CRR_PRESSED:
               if (!btn_s)
                  state_q <= pulse_ok ? crr_pkg::CRR_RELEASE : crr_pkg::CRR_WAIT;
            crr_pkg::CRR_RELEASE:
               state_q <= crr_pkg::CRR_RELEASE;
         endcase
      end
   end

   // registered outputs
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         status <= '0;
      else
      begin
         status.cond_ok    <= cond;
         status.release_on <= cond && state_q == crr_pkg::CRR_RELEASE;
         status.reset_req  <= cond && (state_q == crr_pkg::CRR_WAIT || state_q == crr_pkg::CRR_PRESSED)
                              && blink_q;
      end
   end

   // checks
   // accepted press: button let go with a count inside the window
   sequence valid_press_s;
      btn_s ##1 !btn_s && press_ms_q >= min_ms && press_ms_q <= MAX_MS;
   endsequence

   // refused press: button let go before the minimum was reached
   sequence short_press_s;
      btn_s ##1 !btn_s && press_ms_q < min_ms;
   endsequence

   // release only while the condition holds
   release_needs_cond_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !cond |=> !status.release_on)
      else $error("release high after condition lost");
   // registered condition follows the input and
   cond_follows_and_a: assert property (@(posedge mclk) disable iff (!reset_n)
      status.cond_ok == $past(cond))
      else $error("condition output not the input AND");
   // indicator only while waiting
   req_only_waiting_a: assert property (@(posedge mclk) disable iff (!reset_n)
      status.reset_req |-> status.cond_ok && !status.release_on)
      else $error("reset required shown outside waiting");
   // short press goes back to waiting
   short_press_ignored_a: assert property (@(posedge mclk) disable iff (!reset_n)
      state_q == crr_pkg::CRR_PRESSED && cond ##0 short_press_s ##0 cond |=> state_q == crr_pkg::CRR_WAIT)
      else $error("short reset pulse accepted");
   // overlong press never releases
   long_press_ignored_a: assert property (@(posedge mclk) disable iff (!reset_n)
      state_q == crr_pkg::CRR_PRESSED && press_ms_q > MAX_MS ##1 !btn_s && cond |=> state_q != crr_pkg::CRR_RELEASE)
      else $error("overlong reset pulse accepted");
   // accepted press raises release
   valid_press_releases_a: assert property (@(posedge mclk) disable iff (!reset_n)
      state_q == crr_pkg::CRR_PRESSED && cond ##0 valid_press_s ##0 cond |=> ##1 (status.release_on || !$past(cond)))
      else $error("valid pulse did not release");
   // indicator toggles every half period
   blink_period_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tick_q && blink_ms_q == BLINK_MS - 10'h001 && state_q == crr_pkg::CRR_WAIT |=> blink_q != $past(blink_q))
      else $error("blink did not toggle at half period");
   // minimum pulse length follows the configuration
   min_select_a: assert property (@(posedge mclk) disable iff (!reset_n)
      min_ms == (cfg.min_long ? 15'h15e : 15'h064))
      else $error("wrong minimum pulse selected");
   // tick lands on the counter wrap and lasts one cycle
   tick_spacing_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tick_q |-> tick_cnt_q == '0 ##1 !tick_q)
      else $error("ms tick out of step");
   // only the first input takes part for a count of two
   unused_inputs_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cfg.num_inputs == 4'h2 |-> enable_mask == 7'h01)
      else $error("enable mask wrong for two inputs");
   // every input takes part for a count of eight
   full_inputs_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cfg.num_inputs == 4'h8 |-> enable_mask == 7'h7f)
      else $error("enable mask wrong for eight inputs");
   // losing the condition always returns to idle
   cond_drop_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !cond |=> state_q == crr_pkg::CRR_IDLE)
      else $error("state kept after condition lost");
   // release stays while the condition stays
   release_holds_a: assert property (@(posedge mclk) disable iff (!reset_n)
      status.release_on && cond |=> status.release_on)
      else $error("release dropped with condition held");
   // waiting always starts with the indicator lit
   wait_starts_lit_a: assert property (@(posedge mclk) disable iff (!reset_n)
      state_q == crr_pkg::CRR_WAIT && $past(state_q) == crr_pkg::CRR_IDLE |-> blink_q)
      else $error("indicator not lit on entry to waiting");
endmodule

// *** design/crr_params.svh ***
// timing constants and configuration codes for the contact release block
`ifndef CRR_PARAMS_SVH
`define CRR_PARAMS_SVH
`define CRR_CLK_HZ          200000000
`define CRR_TICK_HZ         1000
`define CRR_TICK_CYC        (`CRR_CLK_HZ / `CRR_TICK_HZ)
`define CRR_MIN_SHORT_MS    100
`define CRR_MIN_LONG_MS     350
`define CRR_MAX_PULSE_MS    30000
`define CRR_BLINK_HALF_MS   500
`define CRR_NUM_REL         7
`define CRR_CNT_MIN_INPUTS  4'h2
`define CRR_CNT_MAX_INPUTS  4'h8
`endif

// *** design/crr_pkg.sv ***
// types shared by the contact release block
package crr_pkg;
   typedef struct packed {
      logic       min_long;   // 1: 350 ms minimum, 0: 100 ms
      logic [3:0] num_inputs; // 2..8, counts the reset input too
   } crr_cfg_type;

   typedef struct packed {
      logic cond_ok;
      logic reset_req;
      logic release_on;
   } crr_out_type;

   typedef enum logic [1:0] {
      CRR_IDLE    = 2'b00,
      CRR_WAIT    = 2'b01,
      CRR_PRESSED = 2'b10,
      CRR_RELEASE = 2'b11
   } crr_state_type;
endpackage

// *** design/crr_sync.sv ***
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module crr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // first stage is read only by the second stage
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// *** verification/crr_contact_model.sv ***
// behavioural model of the pressure contacts and reset pushbutton
`timescale 1ns/10ps
module crr_contact_model (
   input  wire logic       mclk,
   input  wire logic [6:0] close_mask,
   input  wire logic       press,
   output logic      [6:0] release_in,
   output logic            reset_btn
);
   // contacts open and button up until the first edge
   initial
   begin
      release_in = 7'h00;
      reset_btn  = 1'b0;
   end

   // contacts and button move just after the clock edge, as commanded
   always @(posedge mclk)
   begin
      release_in <= close_mask;
      reset_btn  <= press;
   end
endmodule

// *** verification/crr_release_tb.sv ***
// self-checking testbench for the contact release block
`timescale 1ns/10ps
module crr_release_tb;
   logic                 mclk       = 1'b0;
   logic                 reset_n    = 1'b0;
   logic           [6:0] close_mask = 7'h00;
   logic                 press      = 1'b0;
   logic           [6:0] release_in;
   logic                 reset_btn;
   crr_pkg::crr_cfg_type cfg        = '{min_long: 1'b0, num_inputs: 4'h8};
   crr_pkg::crr_out_type status;
   int                   n_errors   = 0;
   int                   n_tests    = 0;
   localparam int        TICK       = 2; // ms tick shortened so a 30 s press fits the run

   // 200 MHz clock
   always #2.5 mclk = ~mclk;

   crr_contact_model crr_contact_model_inst (
      .mclk       (mclk),
      .close_mask (close_mask),
      .press      (press),
      .release_in (release_in),
      .reset_btn  (reset_btn)
   );

   crr_release #(.TICK_CYC(TICK)) crr_release_inst (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .release_in (release_in),
      .reset_btn  (reset_btn),
      .cfg        (cfg),
      .status     (status)
   );

   // compare one value and count it
   task automatic check(input logic [2:0] seen, input logic [2:0] exp);
   begin
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // reset held 8 cycles, then outputs must be low
   task automatic do_reset(input logic ml);
   begin
      reset_n        <= 1'b0;
      cfg.min_long   <= ml;
      cfg.num_inputs <= 4'h8;
      close_mask     <= 7'h00;
      press          <= 1'b0;
      cyc(8);
      reset_n <= 1'b1;
      cyc(2);
      check(status, 3'h0);
   end
   endtask

   // and of enabled inputs for every input count, disabled ones left open
   task automatic t_and;
      logic [6:0] en;
   begin
      for (int n = 2; n <= 8; n++)
      begin
         en = 7'h7f >> (8 - n);
         cfg.num_inputs <= 4'(n);
         close_mask     <= en;
         cyc(6);
         check({status.cond_ok, status.release_on}, 2'h2);
         close_mask <= en >> 1;
         cyc(6);
         check({status.cond_ok, status.release_on}, 2'h0);
      end
      $display("test and done");
   end
   endtask

   // hold the button for a number of ms, then let it settle
   task automatic press_for(input int ms);
   begin
      press <= 1'b1;
      cyc(ms * TICK);
      press <= 1'b0;
      cyc(10);
   end
   endtask

   // waiting indicator, short and mid presses, drop of one contact, fresh pulse needed
   task automatic t_wait(input logic ml);
   begin
      do_reset(ml);
      close_mask <= 7'h7f;
      cyc(6);
      check(status, 3'h6);
      press_for(60);
      check(status, 3'h6);
      press_for(200);
      check(status, ml ? 3'h6 : 3'h5);
      if (ml)
      begin
         press_for(400);
         check(status, 3'h5);
      end
      cyc(40);
      check(status, 3'h5);
      close_mask <= 7'h3f;
      cyc(6);
      check(status, 3'h0);
      close_mask <= 7'h7f;
      cyc(6);
      check(status, 3'h6);
      $display("test wait done, min_long %0d", ml);
   end
   endtask

   // indicator blinks at 1 Hz: 500 ms lit, 500 ms dark
   task automatic t_blink;
   begin
      do_reset(1'b0);
      close_mask <= 7'h7f;
      cyc(6);
      check(status, 3'h6);
      cyc(750 * TICK);
      check(status, 3'h4);
      cyc(500 * TICK);
      check(status, 3'h6);
      $display("test blink done");
   end
   endtask

   // overlong press refused, a valid one afterwards still releases
   task automatic t_long;
   begin
      do_reset(1'b0);
      close_mask <= 7'h7f;
      cyc(6);
      press_for(30005);
      check({status.cond_ok, status.release_on}, 2'h2);
      press_for(200);
      check(status, 3'h5);
      $display("test long done");
   end
   endtask

   // counts, verdict, end of run
   task automatic summarize;
   begin
      $display("tests %0d, errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask

   // main sequence
   initial
   begin
      do_reset(1'b0);
      t_and;
      t_wait(1'b0);
      t_wait(1'b1);
      t_blink;
      t_long;
      summarize;
   end

   // watchdog, tests need about 65000 cycles, gives up after 80000
   initial
   begin
      #400000;
      n_errors++;
      summarize;
   end
endmodule
